// *** src/bcp_bus_control.sv ***
// Bus control register one with address and data pull-up control
//
// Register access over APB and the address map were decided locally.
`timescale 1ns/1ns
module bcp_bus_control
  import bcp_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        sys_rst,       // Power-on reset
  input  wire logic        manualRst,     // Manual reset, register kept
  input  wire logic        standby,       // Standby, register kept
  input  wire logic        endianPin,     // Endian strap pin
  input  wire logic        busReleaseAck, // Acknowledge, active high
  input  wire logic        dataBusBusy,   // Data bus in use
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic      [25:0] addrPullEn,   // Address pin pull-up enables
  output logic      [31:0] dataPullEn    // Data pin pull-up enables
);
  // ==========================================================
  // Input synchronisers
  logic [1:0] ackSync;    // Acknowledge pin synchroniser
  logic [1:0] busySync;   // Data bus busy synchroniser
  logic [1:0] endSync;    // Endian strap synchroniser
  logic [1:0] manSync;    // Manual reset synchroniser
  logic [1:0] stbySync;   // Standby synchroniser
  logic       ackPrev;    // Previous synchronised acknowledge
  logic       endianFlag; // Caught endian level
  logic       strapDone;  // Strap captured after reset release

  // Two flops per pin, second stage is the only reader
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ackSync  <= 2'h0;
      busySync <= 2'h0;
      manSync  <= 2'h0;
      stbySync <= 2'h0;
    end else begin
      ackSync  <= {ackSync[0], busReleaseAck};
      busySync <= {busySync[0], dataBusBusy};
      manSync  <= {manSync[0], manualRst};
      stbySync <= {stbySync[0], standby};
    end
  end

  // Strap flops run through reset so the level is ready at release
  always_ff @(posedge clock) begin
    endSync <= {endSync[0], endianPin};
  end

  // Endian strap caught once after power-on release
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      strapDone  <= 1'b0;
      endianFlag <= 1'b0;
    end else if (!strapDone) begin
      strapDone  <= 1'b1;
      endianFlag <= endSync[1];
    end
  end

  // ==========================================================
  // Register file
  logic [15:0] busControlOne; // Stored writable bits
  logic [15:0] bcrView;       // Readback with endian flag

  wire setupOk   = psel && !penable;
  wire accessOk  = psel && penable && pready;
  wire hitBcr    = (paddr == BCP_OFS_BUS_CONTROL_ONE);
  wire hitMap    = (paddr == BCP_OFS_MAP_STATUS);
  wire mapped    = hitBcr || hitMap;
  wire wrBcr     = accessOk && pwrite && hitBcr;

  assign bcrView = (busControlOne & BCP_BCR_WMASK)
                 | ({15'h0000, endianFlag} << BCP_BIT_ENDIAN);

  // Only power-on reset clears; manual reset, standby kept
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      busControlOne <= BCP_BCR_RESET;
    end else if (wrBcr) begin
      busControlOne <= pwdata[15:0] & BCP_BCR_WMASK;
    end
  end

  // APB answer: one wait-free access phase, error on unmapped
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= setupOk;
      pslverr <= setupOk && !mapped;
      if (setupOk && !pwrite && hitBcr) begin
        prdata <= {16'h0000, bcrView};
      end else if (setupOk && !pwrite && hitMap) begin
        prdata <= {16'h0000, BCP_NUM_MODE_REGS, BCP_NUM_REGS};
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  // ==========================================================
  // Pull-up control
  logic pullActive; // Address pull-up window open
  wire  ackRise = ackSync[1] && !ackPrev;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ackPrev <= 1'b0;
    end else begin
      ackPrev <= ackSync[1];
    end
  end

  bcp_pull_timer u_timer (
    .clock      (clock),
    .sys_rst    (sys_rst),
    .enable     (busControlOne[BCP_BIT_ADDR_PULL]),
    .ackRise    (ackRise),
    .pullActive (pullActive)
  );

  // Pin pull-up enables, registered; no write-protect pin exists
  // Card write-protect is neither sampled nor acted on
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      addrPullEn <= 26'h0;
      dataPullEn <= 32'h0000_0000;
    end else begin
      addrPullEn <= {BCP_ADDR_PINS{pullActive}};
      dataPullEn <= {BCP_DATA_PINS{busControlOne[BCP_BIT_DATA_PULL]
                     && !busySync[1]}};
    end
  end

  // ==========================================================
  // Checks on the register and the pin enables

  // Power-on reset leaves the register cleared
  reset_clear_a: assert property (
    @(posedge clock)
    sys_rst |=> busControlOne == BCP_BCR_RESET)
    else $error("register not cleared by power-on reset");

  // Manual reset and standby leave the stored bits alone
  keep_manual_a: assert property (
    @(posedge clock) disable iff (sys_rst)
    (manSync[1] || stbySync[1]) && !wrBcr |=> $stable(busControlOne))
    else $error("register changed on manual reset");

  // Data pull-up off one cycle after the bit reads clear
  data_pull_a: assert property (
    @(posedge clock) disable iff (sys_rst)
    !busControlOne[BCP_BIT_DATA_PULL] |=> dataPullEn == 32'h0)
    else $error("data pull-up while disabled");

  // Data pins released while the bus carries traffic
  data_busy_a: assert property (
    @(posedge clock) disable iff (sys_rst)
    busySync[1] |=> dataPullEn == 32'h0)
    else $error("data pull-up while bus busy");

  // Data pins pulled up when enabled and idle
  data_idle_a: assert property (
    @(posedge clock) disable iff (sys_rst)
    busControlOne[BCP_BIT_DATA_PULL] && !busySync[1]
      |=> dataPullEn == {BCP_DATA_PINS{1'b1}})
    else $error("data pull-up missing while idle");

  // Address enables follow an open window one cycle late
  addr_on_a: assert property (
    @(posedge clock) disable iff (sys_rst)
    pullActive |=> addrPullEn == {BCP_ADDR_PINS{1'b1}})
    else $error("address pull-up missing in window");

  // Address enables low outside the window
  addr_off_a: assert property (
    @(posedge clock) disable iff (sys_rst)
    !pullActive |=> addrPullEn == 26'h0)
    else $error("address pull-up outside window");

  // Access phase answered in the cycle right after setup
  apb_ready_a: assert property (
    @(posedge clock) disable iff (sys_rst)
    setupOk |=> pready)
    else $error("no single-cycle answer");

  // No answer without a setup phase before it
  apb_idle_a: assert property (
    @(posedge clock) disable iff (sys_rst)
    !setupOk |=> !pready)
    else $error("answer without setup phase");

  // Unmapped address answered with an error and zero data
  unmapped_err_a: assert property (
    @(posedge clock) disable iff (sys_rst)
    setupOk && !mapped |=> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped access not refused");

  // Write lands in the stored bits
  reg_write_a: assert property (
    @(posedge clock) disable iff (sys_rst)
    wrBcr |=> busControlOne == (16'($past(pwdata)) & BCP_BCR_WMASK))
    else $error("write not stored");

  // Writes elsewhere leave the register alone
  other_write_a: assert property (
    @(posedge clock) disable iff (sys_rst)
    accessOk && pwrite && !hitBcr |=> $stable(busControlOne))
    else $error("register changed by a write elsewhere");
endmodule : bcp_bus_control

// *** src/bcp_pkg.sv ***
// Constants for the bus control pull-up configuration block
package bcp_pkg;
  // ==========================================================
  // Register map and layout
  localparam logic [11:0] BCP_OFS_BUS_CONTROL_ONE = 12'h000;
  localparam logic [11:0] BCP_OFS_MAP_STATUS      = 12'h004;
  localparam int          BCP_REG_WIDTH           = 16;
  localparam logic [15:0] BCP_BCR_RESET           = 16'h0000;
  localparam logic [15:0] BCP_BCR_WMASK           = 16'hf7ff;
  localparam int          BCP_BIT_ADDR_PULL       = 15;
  localparam int          BCP_BIT_DATA_PULL       = 14;
  localparam int          BCP_BIT_ENDIAN          = 11;
  // Number of controller registers plus mode register
  localparam logic [7:0]  BCP_NUM_REGS            = 8'h0b;
  localparam logic [7:0]  BCP_NUM_MODE_REGS       = 8'h01;
  // ==========================================================
  // Pin widths and timing
  localparam int          BCP_ADDR_PINS           = 26;
  localparam int          BCP_DATA_PINS           = 32;
  localparam int          BCP_PULL_CYCLES         = 4;
  localparam logic [2:0]  BCP_PULL_COUNT          = 3'h4;
endpackage : bcp_pkg

// *** src/bcp_pull_timer.sv ***
// Address pull-up interval timer started by bus-release acknowledge
`timescale 1ns/1ns
module bcp_pull_timer
  import bcp_pkg::*;
(
  input  wire logic clock,
  input  wire logic sys_rst,
  input  wire logic enable,
  input  wire logic ackRise,
  output logic      pullActive
);
  // ==========================================================
  // Cycle counter
  logic [2:0] count;      // Remaining pull-up cycles
  logic [2:0] next_count; // Next counter value
  logic       loadNow;    // Window start: edge seen while enabled

  assign loadNow    = ackRise && enable;
  assign next_count = loadNow ? BCP_PULL_COUNT :
                      (count != 3'h0) ? count - 3'h1 : 3'h0;
  assign pullActive = (count != 3'h0);

  // Counter register, loads on acknowledge edge
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      count <= 3'h0;
    end else begin
      count <= next_count;
    end
  end

  // Window stays open four cycles after the start
  pull_len_a: assert property (
    @(posedge clock) disable iff (sys_rst)
    loadNow |=> pullActive [*4])
    else $error("address pull-up interval too short");

  // Window closes after its last cycle unless restarted
  pull_end_a: assert property (
    @(posedge clock) disable iff (sys_rst)
    (count == 3'h1) && !loadNow |=> !pullActive)
    else $error("address pull-up interval too long");
endmodule : bcp_pull_timer

// *** verif/bcp_bus_partner.sv ***
// Far-side bus owner model: bus release and data bus use
`timescale 1ns/1ns
module bcp_bus_partner (
  input  wire logic clock,
  input  wire logic wantBus,       // Bench asks for the bus
  input  wire logic useData,       // Bench puts traffic on data bus
  output logic      busReleaseAck, // Acknowledge toward the block
  output logic      dataBusBusy    // Data bus in use
);
  // ==========================================================
  // Both lines change only just after a clock edge
  always_ff @(posedge clock) begin
    busReleaseAck <= wantBus;
    dataBusBusy   <= useData;
  end
endmodule : bcp_bus_partner

// *** verif/bus_control_pullup_config_tb.sv ***
// Self-checking bench for the bus control pull-up block
`timescale 1ns/1ns
module bus_control_pullup_config_tb;
  import bcp_pkg::*;
  logic        clock, sys_rst, manualRst, standby, endianPin;
  logic        psel, penable, pwrite, pready, pslverr, err;
  logic        wantBus, useData, busReleaseAck, dataBusBusy;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, d, dataPullEn;
  logic [25:0] addrPullEn;
  int          error_cnt, checks, n;
  bcp_bus_control dut_u (.clock, .sys_rst, .manualRst, .standby,
    .endianPin, .busReleaseAck, .dataBusBusy, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .addrPullEn,
    .dataPullEn);
  bcp_bus_partner far_u (.clock, .wantBus, .useData, .busReleaseAck,
    .dataBusBusy);
  // ==========================================================
  // Clock and watchdog
  initial begin
    clock = 0;
    forever #5 clock = ~clock;
  end
  initial begin
    #200000;
    error_cnt++;
    give_verdict();
  end
  // Compare one value
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // One APB transfer, result left in rd and err
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] wd);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clock) penable <= 1;
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge clock);
  endtask : xfer
  // Power-on reset held eight cycles
  task automatic do_reset;
    sys_rst <= 1;
    repeat (8) @(posedge clock);
    sys_rst <= 0;
    repeat (4) @(posedge clock);
  endtask : do_reset
  // Read-back value of the register after a write
  function automatic logic [31:0] exp_reg(logic [31:0] w, logic e);
    return {16'h0, w[15:0] & BCP_BCR_WMASK} | {20'h0, e, 11'h0};
  endfunction : exp_reg
  task automatic give_verdict;
    $display("checks=%0d error_cnt=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : give_verdict
  // ==========================================================
  // Main sequence
  initial begin
    {manualRst, standby, endianPin, psel, penable} = '0;
    sys_rst = 1;
    {pwrite, wantBus, useData, paddr, pwdata} = '0;
    error_cnt = 0;
    checks = 0;
    void'($urandom(32'hfcc302e7));
    @(posedge clock);
    do_reset();
    xfer(0, BCP_OFS_BUS_CONTROL_ONE, 0);
    chk(rd, 0);
    xfer(0, BCP_OFS_MAP_STATUS, 0);
    chk(rd, 32'h0000010b);
    xfer(1, 12'h0f0, '1);
    chk({31'h0, err}, 1);
    chk(rd, 0);
    // Register set up first, corners then random words
    for (int i = 0; i < 10; i++) begin
      d = (i < 2) ? {32{i[0]}} : $urandom;
      xfer(1, BCP_OFS_BUS_CONTROL_ONE, d);
      xfer(0, BCP_OFS_BUS_CONTROL_ONE, 0);
      chk(rd, exp_reg(d, 0));
      chk({31'h0, err}, 0);
    end
    // Manual reset and standby leave the register alone
    manualRst <= 1;
    standby <= 1;
    repeat (3) @(posedge clock);
    manualRst <= 0;
    standby <= 0;
    xfer(0, BCP_OFS_BUS_CONTROL_ONE, 0);
    chk(rd, exp_reg(d, 0));
    // All four pull-up settings
    for (int m = 0; m < 4; m++) begin
      xfer(1, BCP_OFS_BUS_CONTROL_ONE, {16'h0, 2'(m), 14'h0});
      repeat (6) @(posedge clock);
      chk(dataPullEn, {32{m[0]}});
      useData <= 1;
      repeat (6) @(posedge clock);
      chk(dataPullEn, 0);
      wantBus <= 1;
      n = 0;
      repeat (20) @(posedge clock) if (addrPullEn === '1) n++;
      chk(n, m[1] ? 4 : 0);
      wantBus <= 0;
      useData <= 0;
      repeat (4) @(posedge clock);
    end
    // Second power-on with the endian strap high
    endianPin <= 1;
    do_reset();
    chk(dataPullEn, 0);
    xfer(0, BCP_OFS_BUS_CONTROL_ONE, 0);
    chk(rd, 32'h00000800);
    give_verdict();
  end
endmodule : bus_control_pullup_config_tb
